// file: rtl/wakeup_counter.sv
// module: periodic wakeup counter with AXI4-Lite register slave
`timescale 1ns/1ns
module wakeup_counter
(
  // clock and reset
  input  wire logic        clk_in,
  input  wire logic        rst_n_in,
  // write address channel
  input  wire logic        awvalid_in,
  output logic             awready_out,
  input  wire logic [3:0]  awaddr_in,
  input  wire logic [2:0]  awprot_in,
  // write data channel
  input  wire logic        wvalid_in,
  output logic             wready_out,
  input  wire logic [31:0] wdata_in,
  input  wire logic [3:0]  wstrb_in,
  // write response channel
  output logic             bvalid_out,
  input  wire logic        bready_in,
  output logic [1:0]       bresp_out,
  // read address channel
  input  wire logic        arvalid_in,
  output logic             arready_out,
  input  wire logic [3:0]  araddr_in,
  input  wire logic [2:0]  arprot_in,
  // read data channel
  output logic             rvalid_out,
  input  wire logic        rready_in,
  output logic [31:0]      rdata_out,
  output logic [1:0]       rresp_out,
  // clock source pins
  input  wire logic        low_power_osc_in,
  input  wire logic        external_ref_clock_in,
  input  wire logic        internal_ref_clock_in,
  // debug halt and interrupt
  input  wire logic        debug_halt_in,
  output logic             irq_out
);
  // whole state in one word
  typedef struct packed
  {
    logic       aw_held;  // write address waiting
    logic [3:0] aw_addr;  // held write address
    logic       w_held;   // write data waiting
    logic [7:0] w_data;   // held low byte
    logic       w_strb0;  // low lane enabled
    logic       bvalid;   // write answer pending
    logic [1:0] bresp;    // write answer code
    logic       rvalid;   // read answer pending
    logic [7:0] rdata;    // read byte
    logic [1:0] rresp;    // read answer code
    logic [1:0] src_sel;  // source_select
    logic [3:0] div_sel;  // divider_select
    logic       irq_en;   // tick_irq_enable
    logic       flag;     // tick_flag
    logic [7:0] count;    // current_count
    logic [7:0] wrap;     // wrap_value
    logic       irq;      // interrupt request
  } state_t;

  state_t s_r;      // registered state
  state_t s_nxt;    // next state
  logic   do_wr;    // both write halves present
  logic   cfg_clr;  // clear prescaler and count
  logic   tick_w;   // counting tick this cycle
  logic   flag_set; // wrap event this cycle
  logic   w1c;      // software clears flag
  logic   wr_ctrl;  // write hits control
  logic   wr_wrap;  // write hits wrap value
  logic   osc_rise; // oscillator edge
  logic   ext_rise; // external edge
  logic   int_rise; // internal edge
  logic   src_rise; // selected edge
  logic   presc_tk; // prescaler tick

  // pins cross into the bus clock; no second domain to manage
  edge_sync u_sync_osc
  (
    .clk_in   (clk_in),
    .rst_n_in (rst_n_in),
    .pin_in   (low_power_osc_in),
    .rise_out (osc_rise)
  );

  edge_sync u_sync_ext
  (
    .clk_in   (clk_in),
    .rst_n_in (rst_n_in),
    .pin_in   (external_ref_clock_in),
    .rise_out (ext_rise)
  );

  edge_sync u_sync_int
  (
    .clk_in   (clk_in),
    .rst_n_in (rst_n_in),
    .pin_in   (internal_ref_clock_in),
    .rise_out (int_rise)
  );

  // source mux; a glitch on switching is harmless since a change clears prescaler and count
  always_comb
  begin
    if (s_r.src_sel[1])
      src_rise = int_rise;
    else if (s_r.src_sel == wakeup_pkg::SRC_EXT)
      src_rise = ext_rise;
    else
      src_rise = osc_rise;
  end

  // prescaler sees the same clear as the count, in the same cycle
  tick_prescaler u_presc
  (
    .clk_in     (clk_in),
    .rst_n_in   (rst_n_in),
    .clear_in   (cfg_clr),
    .hold_in    (debug_halt_in),
    .src_lo_in  (s_r.src_sel[0]),
    .div_sel_in (s_r.div_sel),
    .edge_in    (src_rise),
    .tick_out   (presc_tk)
  );

  // handshakes from state; one write and one read in flight
  assign awready_out = !s_r.aw_held && !s_r.bvalid;
  assign wready_out  = !s_r.w_held && !s_r.bvalid;
  assign arready_out = !s_r.rvalid;

  // bus slave and counter next state
  always_comb
  begin
    s_nxt    = s_r;
    do_wr    = s_r.aw_held && s_r.w_held && !s_r.bvalid;
    wr_ctrl  = do_wr && s_r.w_strb0 && s_r.aw_addr == wakeup_pkg::OFF_CTRL;
    wr_wrap  = do_wr && s_r.w_strb0 && s_r.aw_addr == wakeup_pkg::OFF_WRAP;
    tick_w   = presc_tk && !debug_halt_in;
    flag_set = 1'b0;
    w1c      = wr_ctrl && s_r.w_data[wakeup_pkg::FLAG_BIT];
    cfg_clr  = wr_wrap;
    // address and data halves, in either order
    if (awvalid_in && awready_out)
    begin
      s_nxt.aw_held = 1'b1;
      s_nxt.aw_addr = awaddr_in;
    end
    if (wvalid_in && wready_out)
    begin
      s_nxt.w_held  = 1'b1;
      s_nxt.w_data  = wdata_in[7:0];
      s_nxt.w_strb0 = wstrb_in[0];
    end
    // perform the write once both halves are here
    if (do_wr)
    begin
      s_nxt.aw_held = 1'b0;
      s_nxt.w_held  = 1'b0;
      s_nxt.bvalid  = 1'b1;
      // count offset is mapped but takes nothing
      if (s_r.aw_addr == wakeup_pkg::OFF_CTRL || s_r.aw_addr == wakeup_pkg::OFF_COUNT ||
          s_r.aw_addr == wakeup_pkg::OFF_WRAP)
        s_nxt.bresp = wakeup_pkg::RESP_OKAY;
      else
        s_nxt.bresp = wakeup_pkg::RESP_SLV;
    end
    // control fields; only a changed value clears
    if (wr_ctrl)
    begin
      s_nxt.src_sel = s_r.w_data[wakeup_pkg::SRC_LO +: 2];
      s_nxt.div_sel = s_r.w_data[wakeup_pkg::DIV_LO +: 4];
      s_nxt.irq_en  = s_r.w_data[wakeup_pkg::IRQEN_BIT];
      if (s_nxt.src_sel != s_r.src_sel || s_nxt.div_sel != s_r.div_sel)
        cfg_clr = 1'b1;
    end
    // wrap value takes any byte
    if (wr_wrap)
      s_nxt.wrap = s_r.w_data;
    // write answer retires
    if (s_r.bvalid && bready_in)
      s_nxt.bvalid = 1'b0;
    // read: answer one cycle after the address is taken
    if (arvalid_in && arready_out)
    begin
      s_nxt.rvalid = 1'b1;
      s_nxt.rresp  = wakeup_pkg::RESP_OKAY;
      unique case (araddr_in)
        wakeup_pkg::OFF_CTRL:  s_nxt.rdata = {s_r.flag, s_r.src_sel, s_r.irq_en, s_r.div_sel};
        wakeup_pkg::OFF_COUNT: s_nxt.rdata = s_r.count;
        wakeup_pkg::OFF_WRAP:  s_nxt.rdata = s_r.wrap;
        default:
        begin
          s_nxt.rdata = 8'h00;
          s_nxt.rresp = wakeup_pkg::RESP_SLV;
        end
      endcase
    end
    else if (s_r.rvalid && rready_in)
      s_nxt.rvalid = 1'b0;
    // counter: clear wins over a tick in the same cycle
    if (cfg_clr)
      s_nxt.count = wakeup_pkg::COUNT_RST;
    else if (tick_w)
    begin
      if (s_r.count == s_r.wrap)
      begin
        s_nxt.count = wakeup_pkg::COUNT_RST;
        flag_set    = 1'b1;
      end
      else
        s_nxt.count = s_r.count + 8'h01;
    end
    // set beats a clear that lands in the same cycle
    s_nxt.flag = (s_r.flag && !w1c) || flag_set;
    s_nxt.irq  = s_nxt.flag && s_nxt.irq_en;
  end

  // state register; reset leaves the counter stopped on the oscillator
  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      s_r         <= '0;
      s_r.src_sel <= wakeup_pkg::SRC_RST;
      s_r.div_sel <= wakeup_pkg::DIV_RST;
      s_r.wrap    <= wakeup_pkg::WRAP_RST;
      s_r.count   <= wakeup_pkg::COUNT_RST;
    end
    else
      s_r <= s_nxt;
  end

  // outputs from registers; upper data bits read as zero
  assign bvalid_out = s_r.bvalid;
  assign bresp_out  = s_r.bresp;
  assign rvalid_out = s_r.rvalid;
  assign rresp_out  = s_r.rresp;
  assign rdata_out  = {24'h00_0000, s_r.rdata};
  assign irq_out    = s_r.irq;

  // count register ignores writes
  a_count_readonly:
  assert property (@(posedge clk_in) disable iff (!rst_n_in)
    do_wr && s_r.aw_addr == wakeup_pkg::OFF_COUNT && !tick_w |=> $stable(s_r.count))
    else $error("count changed by a write");

  // wrap write clears the count next cycle
  a_wrap_clears:
  assert property (@(posedge clk_in) disable iff (!rst_n_in)
    wr_wrap |=> s_r.count == 8'h00 && s_r.wrap == $past(s_r.w_data))
    else $error("wrap write did not clear count");

  // changed select clears the count
  a_select_clears:
  assert property (@(posedge clk_in) disable iff (!rst_n_in)
    wr_ctrl && s_r.w_data[6:5] != s_r.src_sel |=> s_r.count == 8'h00)
    else $error("source change did not clear count");

  // step by one below the wrap value
  a_count_step:
  assert property (@(posedge clk_in) disable iff (!rst_n_in)
    tick_w && !cfg_clr && s_r.count != s_r.wrap |=> s_r.count == $past(s_r.count) + 8'h01)
    else $error("count did not step by one");

  // wrap to zero raises the flag
  a_wrap_flag:
  assert property (@(posedge clk_in) disable iff (!rst_n_in)
    tick_w && !cfg_clr && s_r.count == s_r.wrap |=> s_r.count == 8'h00 && s_r.flag)
    else $error("wrap did not set flag");

  // request follows flag and enable
  a_irq_gate:
  assert property (@(posedge clk_in) disable iff (!rst_n_in)
    irq_out == (s_r.flag && s_r.irq_en))
    else $error("irq does not match flag and enable");

  // one clears the flag when no event lands
  a_flag_w1c:
  assert property (@(posedge clk_in) disable iff (!rst_n_in)
    w1c && !flag_set |=> !s_r.flag && !irq_out)
    else $error("flag not cleared by one");

  // zero leaves the flag alone
  a_flag_w0:
  assert property (@(posedge clk_in) disable iff (!rst_n_in)
    wr_ctrl && !s_r.w_data[7] && s_r.flag |=> s_r.flag)
    else $error("flag lost on write of zero");

  // debug halt freezes the count
  a_halt_hold:
  assert property (@(posedge clk_in) disable iff (!rst_n_in)
    debug_halt_in && !cfg_clr |=> $stable(s_r.count))
    else $error("count moved during halt");

  // divider off produces no tick
  a_div_off:
  assert property (@(posedge clk_in) disable iff (!rst_n_in)
    s_r.div_sel == 4'h0 [*2] |-> !presc_tk)
    else $error("tick with prescaler off");

  // wrap value zero flags every prescaler tick
  a_zero_wrap:
  assert property (@(posedge clk_in) disable iff (!rst_n_in)
    tick_w && !cfg_clr && s_r.wrap == 8'h00 |=> s_r.flag && s_r.count == 8'h00)
    else $error("zero wrap did not flag a tick");

  // changed divider clears the count
  a_divider_clears:
  assert property (@(posedge clk_in) disable iff (!rst_n_in)
    wr_ctrl && s_r.w_data[wakeup_pkg::DIV_LO +: 4] != s_r.div_sel |=> s_r.count == 8'h00)
    else $error("divider change did not clear count");

  // same source and divider leave the count running
  a_same_cfg_keeps:
  assert property (@(posedge clk_in) disable iff (!rst_n_in)
    wr_ctrl && s_r.w_data[wakeup_pkg::SRC_LO +: 2] == s_r.src_sel &&
      s_r.w_data[wakeup_pkg::DIV_LO +: 4] == s_r.div_sel && !tick_w |=> $stable(s_r.count))
    else $error("unchanged control write cleared count");

  // count never runs past the wrap value
  a_count_range:
  assert property (@(posedge clk_in) disable iff (!rst_n_in)
    s_r.count <= s_r.wrap)
    else $error("count above wrap value");

  // clearing write also empties the prescaler
  a_presc_clear:
  assert property (@(posedge clk_in) disable iff (!rst_n_in)
    cfg_clr |=> !presc_tk)
    else $error("prescaler ticked after a clear");

  // halt stops prescaler ticks as well
  a_halt_no_tick:
  assert property (@(posedge clk_in) disable iff (!rst_n_in)
    debug_halt_in |=> !presc_tk)
    else $error("prescaler ticked during halt");

  // reset leaves everything stopped and cleared
  a_reset_values:
  assert property (@(posedge clk_in)
    !rst_n_in |=> s_r.count == wakeup_pkg::COUNT_RST && s_r.wrap == wakeup_pkg::WRAP_RST &&
      s_r.src_sel == wakeup_pkg::SRC_OSC && s_r.div_sel == wakeup_pkg::DIV_OFF && !s_r.irq_en && !s_r.flag)
    else $error("state not cleared by reset");
endmodule : wakeup_counter

// file: rtl/wakeup_pkg.sv
// package: register map, field layout, reset values and divide table of the wakeup counter
// Overview of operation
// - count register is read-only, writes ignored
// - reset, wrap write, config change clear count
// - any wrap write clears prescaler and count
// - wrap zero flags every prescaler tick
// - wrap value resets to zero
// - after reset: stopped, zero, off, oscillator
// - prescaler off while divider code zero
// - source 00 osc, 01 external, 1x internal
// - changed source select clears prescaler, count
// - changed divider select clears prescaler, count
// - ratio from divider code and source bit
// - count up per tick, wrap to zero
// - wrap accepts full 8-bit range
// - flag sets on wrap-to-zero transition
// - irq while flag and enable set
// - writing one clears flag and request
// - oscillator source code A divides by four
// - codes 1-7 binary, 8-15 decimal ratios, except 4 and 16 at codes A and C with source bit 0 clear
// - writing zero leaves flag unchanged
// - debug halt pauses all counting
package wakeup_pkg;
  // bus geometry
  localparam int unsigned ADDR_W   = 4;
  localparam int unsigned DATA_W   = 32;
  // register byte offsets
  localparam logic [3:0]  OFF_CTRL  = 4'h0;
  localparam logic [3:0]  OFF_COUNT = 4'h4;
  localparam logic [3:0]  OFF_WRAP  = 4'h8;
  // control register field positions
  localparam int unsigned FLAG_BIT  = 7;
  localparam int unsigned SRC_LO    = 5;
  localparam int unsigned IRQEN_BIT = 4;
  localparam int unsigned DIV_LO    = 0;
  // reset values
  localparam logic [1:0]  SRC_RST   = 2'h0;
  localparam logic [3:0]  DIV_RST   = 4'h0;
  localparam logic [7:0]  WRAP_RST  = 8'h00;
  localparam logic [7:0]  COUNT_RST = 8'h00;
  // source select encodings and divider off code
  localparam logic [1:0]  SRC_OSC   = 2'h0;
  localparam logic [1:0]  SRC_EXT   = 2'h1;
  localparam logic [3:0]  DIV_OFF   = 4'h0;
  // write response codes
  localparam logic [1:0]  RESP_OKAY = 2'h0;
  localparam logic [1:0]  RESP_SLV  = 2'h2;
  // divide ratios, source bit 0 clear
  localparam logic [17:0] RATIO_LO [0:15] = '{
    18'h0_0000, 18'h0_0008, 18'h0_0020, 18'h0_0040,
    18'h0_0080, 18'h0_0100, 18'h0_0200, 18'h0_0400,
    18'h0_0001, 18'h0_0002, 18'h0_0004, 18'h0_000A,
    18'h0_0010, 18'h0_0064, 18'h0_01F4, 18'h0_03E8};
  // divide ratios, source bit 0 set
  localparam logic [17:0] RATIO_HI [0:15] = '{
    18'h0_0000, 18'h0_0400, 18'h0_0800, 18'h0_1000,
    18'h0_2000, 18'h0_4000, 18'h0_8000, 18'h1_0000,
    18'h0_03E8, 18'h0_07D0, 18'h0_1388, 18'h0_2710,
    18'h0_4E20, 18'h0_C350, 18'h1_86A0, 18'h3_0D40};
endpackage : wakeup_pkg

// file: rtl/edge_sync.sv
// module: three-stage synchroniser with rising-edge pulse for a source clock pin
`timescale 1ns/1ns
module edge_sync
(
  // clock and reset
  input  wire logic clk_in,
  input  wire logic rst_n_in,
  // raw pin and synchronised edge
  input  wire logic pin_in,
  output logic      rise_out
);
  // whole state in one word
  typedef struct packed
  {
    logic s1;
    logic s2;
    logic s3;
    logic lvl;
    logic rise;
  } sync_t;

  sync_t s_r;   // registered state
  sync_t s_nxt; // next state

  // s1 feeds only s2; level moves once s2 and s3 agree
  always_comb
  begin
    s_nxt      = s_r;
    s_nxt.s1   = pin_in;
    s_nxt.s2   = s_r.s1;
    s_nxt.s3   = s_r.s2;
    s_nxt.rise = 1'b0;
    if (s_r.s2 == s_r.s3)
    begin
      s_nxt.lvl  = s_r.s3;
      s_nxt.rise = s_r.s3 & ~s_r.lvl;
    end
  end

  // state register
  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
      s_r <= '0;
    else
      s_r <= s_nxt;
  end

  assign rise_out = s_r.rise;
endmodule : edge_sync

// file: rtl/tick_prescaler.sv
// module: prescaler that turns source edges into one-cycle ticks
`timescale 1ns/1ns
module tick_prescaler
(
  // clock and reset
  input  wire logic       clk_in,
  input  wire logic       rst_n_in,
  // control
  input  wire logic       clear_in,
  input  wire logic       hold_in,
  input  wire logic       src_lo_in,
  input  wire logic [3:0] div_sel_in,
  input  wire logic       edge_in,
  // tick out
  output logic            tick_out
);
  // whole state in one word
  typedef struct packed
  {
    logic [17:0] cnt;
    logic        tick;
  } presc_t;

  presc_t      s_r;   // registered state
  presc_t      s_nxt; // next state
  logic [17:0] ratio; // selected divide ratio

  // ratio lookup and edge counting
  always_comb
  begin
    ratio = src_lo_in ? wakeup_pkg::RATIO_HI[div_sel_in] : wakeup_pkg::RATIO_LO[div_sel_in];
    s_nxt      = s_r;
    s_nxt.tick = 1'b0;
    if (clear_in || div_sel_in == wakeup_pkg::DIV_OFF)
      s_nxt.cnt = '0;
    else if (edge_in && !hold_in)
    begin
      if (s_r.cnt == ratio - 18'h0_0001)
      begin
        s_nxt.cnt  = '0;
        s_nxt.tick = 1'b1;
      end
      else
        s_nxt.cnt = s_r.cnt + 18'h0_0001;
    end
  end

  // state register
  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
      s_r <= '0;
    else
      s_r <= s_nxt;
  end

  assign tick_out = s_r.tick;
endmodule : tick_prescaler

// file: verification/wakeup_counter_tb.sv
// testbench: register-level checks of the periodic wakeup counter over AXI4-Lite
`timescale 1ns/1ns
module wakeup_counter_tb;
  // clock and reset
  logic        clk_in;
  logic        rst_n_in;
  // bus handshakes
  logic        awvalid_in, awready_out, wvalid_in, wready_out;
  logic        bvalid_out, bready_in, arvalid_in, arready_out;
  logic        rvalid_out, rready_in;
  // bus payloads
  logic [3:0]  awaddr_in, araddr_in, wstrb_in;
  logic [31:0] wdata_in, rdata_out;
  logic [1:0]  bresp_out, rresp_out;
  // source pins, debug halt, interrupt
  logic [2:0]  pins = 3'h0;
  logic [2:0]  pin_en;
  logic        debug_halt_in;
  logic        irq_out;
  // bookkeeping
  int          num_errors = 0;
  int          checked    = 0;
  int          cyc        = 0;
  int          ph         = 0;
  int          p;
  logic [31:0] d, c1;
  logic [1:0]  r;
  logic [7:0]  ctl;

  wakeup_counter dut_u (
    .clk_in                (clk_in),
    .rst_n_in              (rst_n_in),
    .awvalid_in            (awvalid_in),
    .awready_out           (awready_out),
    .awaddr_in             (awaddr_in),
    .awprot_in             (3'h0),
    .wvalid_in             (wvalid_in),
    .wready_out            (wready_out),
    .wdata_in              (wdata_in),
    .wstrb_in              (wstrb_in),
    .bvalid_out            (bvalid_out),
    .bready_in             (bready_in),
    .bresp_out             (bresp_out),
    .arvalid_in            (arvalid_in),
    .arready_out           (arready_out),
    .araddr_in             (araddr_in),
    .arprot_in             (3'h0),
    .rvalid_out            (rvalid_out),
    .rready_in             (rready_in),
    .rdata_out             (rdata_out),
    .rresp_out             (rresp_out),
    .low_power_osc_in      (pins[0]),
    .external_ref_clock_in (pins[1]),
    .internal_ref_clock_in (pins[2]),
    .debug_halt_in         (debug_halt_in),
    .irq_out               (irq_out)
  );

  // 100 MHz system clock
  initial
  begin
    clk_in = 1'b0;
    forever #5 clk_in = ~clk_in;
  end

  // enabled source pins toggle every 4 cycles, a stopped pin just holds its level
  always @(posedge clk_in)
  begin
    cyc <= cyc + 1;
    ph  <= (ph == 3) ? 0 : ph + 1;
    if (ph == 3)
      pins <= pins ^ pin_en;
  end

  // value compare, counts every call
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp)
    begin
      num_errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // one write; ready sampled at negedge so the handshake edge is never raced
  task automatic wr(input logic [3:0] a, input logic [7:0] v, output logic [1:0] resp);
    logic ah, wh, bv, aw_done, w_done;
    @(posedge clk_in);
    awaddr_in  <= a;
    wdata_in   <= {24'h00_0000, v};
    awvalid_in <= 1'b1;
    wvalid_in  <= 1'b1;
    bready_in  <= 1'b1;
    aw_done = 1'b0;
    w_done  = 1'b0;
    bv      = 1'b0;
    while (!bv)
    begin
      @(negedge clk_in);
      ah   = awready_out & ~aw_done;
      wh   = wready_out & ~w_done;
      bv   = bvalid_out & aw_done & w_done;
      resp = bresp_out;
      @(posedge clk_in);
      if (ah)
        awvalid_in <= 1'b0;
      if (wh)
        wvalid_in <= 1'b0;
      aw_done = aw_done | ah;
      w_done  = w_done | wh;
    end
    bready_in <= 1'b0;
  endtask : wr

  // one read, rready held from the start
  task automatic rd(input logic [3:0] a, output logic [31:0] v, output logic [1:0] resp);
    logic ah, rv, ar_done;
    @(posedge clk_in);
    araddr_in  <= a;
    arvalid_in <= 1'b1;
    rready_in  <= 1'b1;
    ar_done = 1'b0;
    rv      = 1'b0;
    while (!rv)
    begin
      @(negedge clk_in);
      ah   = arready_out & ~ar_done;
      rv   = rvalid_out & ar_done;
      v    = rdata_out;
      resp = rresp_out;
      @(posedge clk_in);
      if (ah)
        arvalid_in <= 1'b0;
      ar_done = ar_done | ah;
    end
    rready_in <= 1'b0;
  endtask : rd

  // times two flag raises; flag checks fit inside one period (32 cycles or more)
  task automatic measure(input logic [7:0] wrap, input logic [7:0] cfg, input int exp);
    int t0;
    wr(wakeup_pkg::OFF_CTRL, {1'b1, cfg[6:0]}, r);
    wr(wakeup_pkg::OFF_WRAP, wrap, r);
    do @(negedge clk_in); while (irq_out !== 1'b1);
    t0 = cyc;
    rd(wakeup_pkg::OFF_CTRL, d, r);
    chk(d, {1'b1, cfg[6:0]});
    rd(wakeup_pkg::OFF_COUNT, d, r);
    chk(d, 8'h00);
    wr(wakeup_pkg::OFF_CTRL, {1'b0, cfg[6:0]}, r);
    rd(wakeup_pkg::OFF_CTRL, d, r);
    chk(d, {1'b1, cfg[6:0]});
    wr(wakeup_pkg::OFF_CTRL, {1'b1, cfg[6:0]}, r);
    rd(wakeup_pkg::OFF_CTRL, d, r);
    chk(d, {1'b0, cfg[6:0]});
    do @(negedge clk_in); while (irq_out !== 1'b0);
    do @(negedge clk_in); while (irq_out !== 1'b1);
    chk(cyc - t0, exp);
  endtask : measure

  // count must be running before the write and zero right after it
  task automatic clear_chk(input logic [3:0] a, input logic [7:0] v);
    repeat (100) @(posedge clk_in);
    rd(wakeup_pkg::OFF_COUNT, c1, r);
    wr(a, v, r);
    rd(wakeup_pkg::OFF_COUNT, d, r);
    chk({c1 != 0, d[7:0]}, 9'h100);
  endtask : clear_chk

  // verdict, the only way out
  task automatic results;
    $display("errors %0d, checks %0d", num_errors, checked);
    if (num_errors == 0 && checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : results

  // watchdog: tests take about 34000 cycles
  initial
  begin
    #600_000;
    num_errors++;
    $display("Error at %0t: timeout", $time);
    results();
  end

  // main sequence
  initial
  begin
    rst_n_in      = 1'b0;
    awvalid_in    = 1'b0;
    wvalid_in     = 1'b0;
    bready_in     = 1'b0;
    arvalid_in    = 1'b0;
    rready_in     = 1'b0;
    awaddr_in     = 4'h0;
    araddr_in     = 4'h0;
    wstrb_in      = 4'hF;
    wdata_in      = 32'h0000_0000;
    pin_en        = 3'h0;
    debug_halt_in = 1'b0;
    repeat (12) @(posedge clk_in);
    rst_n_in <= 1'b1;
    // reset values, then an unmapped address
    rd(wakeup_pkg::OFF_CTRL, d, r);
    chk(d, 8'h00);
    rd(wakeup_pkg::OFF_COUNT, d, r);
    chk(d, wakeup_pkg::COUNT_RST);
    rd(wakeup_pkg::OFF_WRAP, d, r);
    chk(d, wakeup_pkg::WRAP_RST);
    rd(4'hC, d, r);
    chk(d, 32'h0000_0000);
    chk(r, wakeup_pkg::RESP_SLV);
    wr(4'hC, 8'h55, r);
    chk(r, wakeup_pkg::RESP_SLV);
    // oscillator running, divider code zero: flag never sets
    pin_en <= 3'h1;
    wr(wakeup_pkg::OFF_CTRL, 8'h10, r);
    repeat (200) @(posedge clk_in);
    rd(wakeup_pkg::OFF_CTRL, d, r);
    chk(d, 8'h10);
    // oscillator, code A: 4 edges of 8 cycles per tick
    measure(8'h03, 8'h1A, 128);
    measure(8'h00, 8'h1A, 32);
    // enable clear: flag still sets, request stays low
    wr(wakeup_pkg::OFF_CTRL, 8'h8A, r);
    repeat (40) @(posedge clk_in);
    @(negedge clk_in);
    chk(irq_out, 1'b0);
    rd(wakeup_pkg::OFF_CTRL, d, r);
    chk(d, 32'h0000_008A);
    // full-range wrap, then halt the count mid-run
    wr(wakeup_pkg::OFF_WRAP, 8'hFF, r);
    rd(wakeup_pkg::OFF_WRAP, d, r);
    chk(d, 8'hFF);
    repeat (200) @(posedge clk_in);
    debug_halt_in <= 1'b1;
    rd(wakeup_pkg::OFF_COUNT, c1, r);
    wr(wakeup_pkg::OFF_COUNT, 8'hAA, r);
    chk(r, wakeup_pkg::RESP_OKAY);
    repeat (100) @(posedge clk_in);
    rd(wakeup_pkg::OFF_COUNT, d, r);
    chk(c1 != 0, 1'b1);
    chk(d, c1);
    debug_halt_in <= 1'b0;
    repeat (100) @(posedge clk_in);
    rd(wakeup_pkg::OFF_COUNT, d, r);
    chk(d > c1, 1'b1);
    // clearing writes
    clear_chk(wakeup_pkg::OFF_CTRL, 8'h19);
    clear_chk(wakeup_pkg::OFF_CTRL, 8'h1A);
    clear_chk(wakeup_pkg::OFF_WRAP, 8'h10);
    clear_chk(wakeup_pkg::OFF_CTRL, 8'h3A);
    // each source code follows only its own pin; odd codes use the decimal 1000 ratio
    for (int s = 0; s < 4; s++)
    begin
      p = (s == 0) ? 0 : (s == 1) ? 1 : 2;
      ctl = {1'b0, s[1:0], 1'b1, 4'h8};
      pin_en <= 3'h7 & ~(3'h1 << p);
      wr(wakeup_pkg::OFF_CTRL, {1'b1, ctl[6:0]}, r);
      wr(wakeup_pkg::OFF_WRAP, 8'h00, r);
      repeat (60) @(posedge clk_in);
      rd(wakeup_pkg::OFF_CTRL, d, r);
      chk(d[7], 1'b0);
      pin_en <= 3'h1 << p;
      measure(s[0] ? 8'h00 : 8'h03, ctl, s[0] ? 8000 : 32);
    end
    results();
  end
endmodule : wakeup_counter_tb
